/* logic/emt_cfg.svh */
// constants of the embedded memory tile: offsets, fields, resets, width codes
// Notes on behaviour
// - quad mode: two reads, two writes together
// - true dual port: any two port operations
// - dual port read+write; single port never concurrent
// - each read and write port sized independently
// - quad/true dual shapes 256x16 down to 4096x1
// - dual/single port also allow 128x32
// - port width ratios limited to sixteen
// - tile splits into two 2048-bit halves
// - synchronous self-timed write, clock edge only
// - read/write mode: write and read enables
// - input/output mode: inputs share input enable
// - per-port read enable, write enable, clear
// - every register clearable locally or globally
// - parallel compare, match flag when found
// - content store holds 32 words of 32
// - don't-care bits never block a match
// - encoded address or sixteen match lines, one per word
// - unencoded: bit 31 selects odd/even bank
// - single match: write two cycles, lookup one
// - multiple match: sixteen lines, two cycles
// - fast multiple match: one cycle, 16 words
// - word write two cycles, three with mask
// - registering selectable per port signal
`ifndef EMT_CFG_SVH
`define EMT_CFG_SVH
// register byte offsets
`define EMT_A_CTRL   8'h00
`define EMT_A_WIDTH  8'h04
`define EMT_A_REGSEL 8'h08
`define EMT_A_STAT   8'h0c
// control fields
`define EMT_F_MODE   0
`define EMT_F_SPLIT  3
`define EMT_F_CLKIO  4
`define EMT_F_CAMM   5
`define EMT_F_UNENC  7
// status fields
`define EMT_F_REJ    0
`define EMT_F_BUSY   1
// reset values
`define EMT_CTRL_RST   8'h00
`define EMT_WIDTH_RST  12'h000
`define EMT_REGSEL_RST 12'h000
// largest width codes: 16 and 32 bits
`define EMT_W16 3'h4
`define EMT_W32 3'h5
`endif

/* logic/emt_pkg.sv */
// types of the embedded memory tile
`default_nettype none
package emt_pkg;
  typedef enum logic [2:0] {
    EMT_QUAD = 3'h0,
    EMT_TDP  = 3'h1,
    EMT_DP   = 3'h2,
    EMT_SP   = 3'h3,
    EMT_CAM  = 3'h4
  } emt_mode_t;
  typedef enum logic [1:0] {
    EMT_SINGLE = 2'h0,
    EMT_MULTI  = 2'h1,
    EMT_FAST   = 2'h2
  } emt_cmode_t;
  typedef enum logic [2:0] {
    EMT_IDLE = 3'b001,
    EMT_WR1  = 3'b010,
    EMT_WR2  = 3'b100
  } emt_cst_t;
  typedef struct packed {
    logic        wr_req;
    logic [11:0] wa;
    logic [31:0] wd;
    logic        rd_req;
    logic [11:0] ra;
  } emt_req_t;
  typedef struct packed {
    logic wr_ce;
    logic rd_ce;
    logic clr;
  } emt_ce_t;
  typedef struct packed {
    logic        wr;
    logic [4:0]  addr;
    logic [31:0] data;
    logic        care_en;
    logic [31:0] dont_care;
  } emt_cwr_t;
  typedef struct packed {
    logic        valid;
    logic        match;
    logic [4:0]  addr;
    logic [15:0] lines;
  } emt_cres_t;
endpackage : emt_pkg
`default_nettype wire

/* logic/emt_tile.sv */
// embedded memory tile: ram modes, content search, wishbone config
`timescale 1ns/1ps
`default_nettype none
`include "emt_cfg.svh"
module emt_tile #(
  parameter int unsigned MEM_BITS  = 32'h1000, // ram bits of the tile
  parameter int unsigned CAM_WORDS = 32'h20,   // content store depth
  parameter int unsigned CAM_BITS  = 32'h20    // content word width
) (
  input  wire logic                    sys_clk,
  input  wire logic                    resetn,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  input  wire emt_pkg::emt_req_t [1:0] port_req,
  input  wire emt_pkg::emt_ce_t  [1:0] port_ce,
  output logic      [1:0][31:0]        port_rdata,
  input  wire emt_pkg::emt_cwr_t       cam_wreq,
  input  wire logic                    cam_look,
  input  wire logic [31:0]             cam_key,
  output var emt_pkg::emt_cres_t       cam_res,
  output logic                         cam_busy
);
  // --------------------------------------------------
  // elaboration checks
  // --------------------------------------------------
  // addressing, split and compare logic serve these sizes only
  if (MEM_BITS != 32'h1000) begin : g_mem_size
    $error("emt_tile: MEM_BITS must be 4096");
  end
  if (CAM_WORDS != 32'h20) begin : g_cam_depth
    $error("emt_tile: CAM_WORDS must be 32");
  end
  if (CAM_BITS != 32'h20) begin : g_cam_width
    $error("emt_tile: CAM_BITS must be 32");
  end

  // --------------------------------------------------
  // state
  // --------------------------------------------------
  typedef struct packed {
    logic [MEM_BITS-1:0]      mem;
    logic [CAM_WORDS-1:0][CAM_BITS-1:0] cdat;
    logic [CAM_WORDS-1:0][CAM_BITS-1:0] ccare;
    logic [7:0]               ctrl;
    logic [11:0]              wid;
    logic [11:0]              rsel;
    logic                     rej;
    emt_pkg::emt_req_t [1:0]  stg;
    logic [1:0][31:0]         r1;
    logic [1:0][31:0]         dout;
    emt_pkg::emt_cst_t        cst;
    emt_pkg::emt_cwr_t        cw;
    logic                     chalf;
    logic [31:0]              ckey;
    emt_pkg::emt_cres_t       cres;
    logic                     ack;
    logic [31:0]              dat;
  } emt_st_t;

  emt_st_t s_q;
  emt_st_t s_d;

  // --------------------------------------------------
  // helpers
  // --------------------------------------------------
  // shape check on a candidate configuration
  function automatic logic cfg_ok(input logic [7:0] c, input logic [11:0] w);
    logic [2:0] mx;
    logic [2:0] mn;
    logic [2:0] v;
    logic       ok;
    mx = 3'h0;
    mn = `EMT_W32;
    ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      v = w[3*i +: 3];
      if (v > `EMT_W32) ok = 1'b0;
      if (v > mx) mx = v;
      if (v < mn) mn = v;
    end
    if (3'(mx - mn) > 3'h4) ok = 1'b0;
    if (mx == `EMT_W32 && c[2:0] < 3'(emt_pkg::EMT_DP)) ok = 1'b0;
    if (c[2:0] > 3'(emt_pkg::EMT_CAM)) ok = 1'b0;
    if (c[`EMT_F_SPLIT] && c[2:0] != 3'(emt_pkg::EMT_DP)
        && c[2:0] != 3'(emt_pkg::EMT_SP)) ok = 1'b0;
    // cam mode code three is not defined
    if (c[`EMT_F_CAMM +: 2] == 2'h3) ok = 1'b0;
    return ok;
  endfunction : cfg_ok

  // bit index of a word, confined to its half when split
  function automatic logic [11:0] bidx(input logic p, input logic sp,
                                       input logic [11:0] a, input logic [2:0] w);
    logic [11:0] x;
    x = 12'(a << w);
    if (sp) x = {p, x[10:0]};
    return x;
  endfunction : bidx

  // masked compare of every stored word
  function automatic logic [31:0] cmp(input emt_st_t s, input logic [31:0] k,
                                      input logic [31:0] m);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 32; i++) begin
      r[i] = ((s.cdat[i] ^ k) & ~s.ccare[i] & m) == 32'h0;
    end
    return r;
  endfunction : cmp

  // --------------------------------------------------
  // next state
  // --------------------------------------------------
  always_comb begin
    emt_pkg::emt_mode_t  md;
    emt_pkg::emt_cmode_t cm;
    emt_pkg::emt_req_t   e;
    logic        sp;
    logic        io;
    logic        cew;
    logic        cer;
    logic        aw;
    logic        ar;
    logic [5:0]  sel;
    logic [2:0]  ww;
    logic [2:0]  rw;
    logic [11:0] ix;
    logic [31:0] rv;
    logic [31:0] bm;
    logic [31:0] m;
    logic [7:0]  nc;
    logic [11:0] nw;
    logic [31:0] wm;
    // decode the configuration, clear the scratch values
    md  = emt_pkg::emt_mode_t'(s_q.ctrl[`EMT_F_MODE +: 3]);
    cm  = emt_pkg::emt_cmode_t'(s_q.ctrl[`EMT_F_CAMM +: 2]);
    e   = '0;
    sp  = s_q.ctrl[`EMT_F_SPLIT];
    io  = s_q.ctrl[`EMT_F_CLKIO];
    cew = 1'b0;
    cer = 1'b0;
    aw  = 1'b0;
    ar  = 1'b0;
    sel = 6'h0;
    ww  = 3'h0;
    rw  = 3'h0;
    ix  = 12'h0;
    rv  = 32'h0;
    bm  = 32'hffffffff;
    m   = 32'h0;
    nc  = s_q.ctrl;
    nw  = s_q.wid;
    wm  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    // every field keeps its value unless changed below
    s_d = s_q;

    // wishbone slave: one wait state, ack for one cycle
    s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;
    s_d.dat = 32'h0;
    if (wb_cyc_i && wb_stb_i && !s_q.ack) begin
      case (wb_adr_i)
        `EMT_A_CTRL:   s_d.dat = {24'h0, s_q.ctrl};
        `EMT_A_WIDTH:  s_d.dat = {20'h0, s_q.wid};
        `EMT_A_REGSEL: s_d.dat = {20'h0, s_q.rsel};
        `EMT_A_STAT: begin
          s_d.dat[`EMT_F_REJ]  = s_q.rej;
          s_d.dat[`EMT_F_BUSY] = s_q.cst != emt_pkg::EMT_IDLE;
        end
        default:       s_d.dat = 32'h0;
      endcase
      // writes merge the enabled byte lanes into the old value
      if (wb_we_i) begin
        case (wb_adr_i)
          `EMT_A_CTRL:   nc = 8'((({24'h0, s_q.ctrl} & ~wm) | (wb_dat_i & wm)));
          `EMT_A_WIDTH:  nw = 12'((({20'h0, s_q.wid} & ~wm) | (wb_dat_i & wm)));
          `EMT_A_REGSEL: s_d.rsel = 12'((({20'h0, s_q.rsel} & ~wm) | (wb_dat_i & wm)));
          `EMT_A_STAT:   if (wb_sel_i[0] && wb_dat_i[`EMT_F_REJ]) s_d.rej = 1'b0;
          default:       s_d.rej = s_d.rej;
        endcase
        if (wb_adr_i == `EMT_A_CTRL || wb_adr_i == `EMT_A_WIDTH) begin
          // illegal shapes are refused and flagged
          if (cfg_ok(nc, nw)) begin
            s_d.ctrl = nc;
            s_d.wid  = nw;
          end else begin
            s_d.rej = 1'b1;
          end
        end
      end
    end

    // ram ports, one pass per port
    for (int p = 0; p < 2; p++) begin
      // enables, stage selects and widths of this port
      cew = port_ce[p].wr_ce;
      cer = io ? port_ce[p].wr_ce : port_ce[p].rd_ce;
      sel = s_q.rsel[6*p +: 6];
      ww  = s_q.wid[6*p +: 3];
      rw  = s_q.wid[6*p+3 +: 3];
      // selectable input registering
      e.wd     = sel[0] ? s_q.stg[p].wd     : port_req[p].wd;
      e.wa     = sel[1] ? s_q.stg[p].wa     : port_req[p].wa;
      e.wr_req = sel[2] ? s_q.stg[p].wr_req : port_req[p].wr_req;
      e.ra     = sel[3] ? s_q.stg[p].ra     : port_req[p].ra;
      e.rd_req = sel[4] ? s_q.stg[p].rd_req : port_req[p].rd_req;
      // write side on write enable, read side by clock scheme
      if (cew) begin
        s_d.stg[p].wd     = port_req[p].wd;
        s_d.stg[p].wa     = port_req[p].wa;
        s_d.stg[p].wr_req = port_req[p].wr_req;
      end
      if (cer) begin
        s_d.stg[p].ra     = port_req[p].ra;
        s_d.stg[p].rd_req = port_req[p].rd_req;
      end
      // which operations the mode lets through
      if (sp) begin
        aw = 1'b1;
        ar = !(md == emt_pkg::EMT_SP && e.wr_req);
      end else begin
        case (md)
          emt_pkg::EMT_QUAD: begin
            aw = 1'b1;
            ar = 1'b1;
          end
          emt_pkg::EMT_TDP: begin
            aw = 1'b1;
            ar = !e.wr_req;
          end
          emt_pkg::EMT_DP: begin
            aw = (p == 0);
            ar = (p == 1);
          end
          emt_pkg::EMT_SP: begin
            aw = (p == 0);
            ar = (p == 0) && !e.wr_req;
          end
          default: begin
            aw = 1'b0;
            ar = 1'b0;
          end
        endcase
      end
      // self-timed write at the clock edge
      if (aw && e.wr_req && cew) begin
        ix = bidx(p[0], sp, e.wa, ww);
        for (int i = 0; i < 32; i++) begin
          if (i < (32'd1 << ww)) s_d.mem[12'(ix + 12'(i))] = e.wd[i];
        end
      end
      // read returns the word held before this edge
      rv = 32'h0;
      if (ar && e.rd_req && cer) begin
        ix = bidx(p[0], sp, e.ra, rw);
        for (int i = 0; i < 32; i++) begin
          if (i < (32'd1 << rw)) rv[i] = s_q.mem[12'(ix + 12'(i))];
        end
        s_d.r1[p] = rv;
        if (!sel[5]) s_d.dout[p] = rv;
      end
      // optional output stage advances on the read enable
      if (sel[5] && port_ce[p].rd_ce) s_d.dout[p] = s_q.r1[p];
      // local clear of this port
      if (port_ce[p].clr) begin
        s_d.stg[p]  = '0;
        s_d.r1[p]   = 32'h0;
        s_d.dout[p] = 32'h0;
      end
    end

    // content write sequence
    case (s_q.cst)
      emt_pkg::EMT_IDLE: begin
        if (md == emt_pkg::EMT_CAM && cam_wreq.wr) begin
          s_d.cw  = cam_wreq;
          s_d.cst = emt_pkg::EMT_WR1;
        end
      end
      emt_pkg::EMT_WR1: begin
        // data goes in first, a plain write clears the mask
        if (!(cm == emt_pkg::EMT_FAST && s_q.cw.addr[4])) begin
          s_d.cdat[s_q.cw.addr] = s_q.cw.data;
          if (!s_q.cw.care_en) s_d.ccare[s_q.cw.addr] = 32'h0;
        end
        s_d.cst = s_q.cw.care_en ? emt_pkg::EMT_WR2 : emt_pkg::EMT_IDLE;
      end
      emt_pkg::EMT_WR2: begin
        // mask lands in the third cycle
        if (!(cm == emt_pkg::EMT_FAST && s_q.cw.addr[4])) begin
          s_d.ccare[s_q.cw.addr] = s_q.cw.dont_care;
        end
        s_d.cst = emt_pkg::EMT_IDLE;
      end
      default: s_d.cst = emt_pkg::EMT_IDLE;
    endcase

    // content lookup
    // results stand for one cycle only
    s_d.cres = '0;
    if (s_q.chalf) begin
      // second half of a multiple-match lookup
      m = cmp(s_q, s_q.ckey, bm);
      s_d.cres.valid = 1'b1;
      s_d.cres.lines = m[31:16];
      s_d.cres.match = |m[31:16];
      s_d.chalf      = 1'b0;
    end else if (md == emt_pkg::EMT_CAM && cam_look && s_q.cst == emt_pkg::EMT_IDLE) begin
      // bank select bit leaves the compare when unencoded
      if (s_q.ctrl[`EMT_F_UNENC] && cm == emt_pkg::EMT_SINGLE) bm = 32'h7fffffff;
      m = cmp(s_q, cam_key, bm);
      s_d.cres.valid = 1'b1;
      case (cm)
        emt_pkg::EMT_SINGLE: begin
          s_d.cres.match = |m;
          // lowest matching word gives the encoded address
          for (int i = 31; i >= 0; i--) begin
            if (m[i]) s_d.cres.addr = 5'(i);
          end
          if (s_q.ctrl[`EMT_F_UNENC]) begin
            s_d.cres.addr = 5'h0;
            for (int k = 0; k < 16; k++) begin
              s_d.cres.lines[k] = m[2*k + (cam_key[31] ? 1 : 0)];
            end
          end
        end
        emt_pkg::EMT_MULTI: begin
          // lower sixteen words now, upper ones next cycle
          s_d.cres.lines = m[15:0];
          s_d.cres.match = |m[15:0];
          s_d.chalf      = 1'b1;
          s_d.ckey       = cam_key;
        end
        emt_pkg::EMT_FAST: begin
          // only the lower sixteen words are searchable
          s_d.cres.lines = m[15:0];
          s_d.cres.match = |m[15:0];
        end
        default: s_d.cres = '0;
      endcase
    end

    // global clear
    if (!resetn) begin
      // cleared content words then match a zero key
      s_d      = '0;
      s_d.cst  = emt_pkg::EMT_IDLE;
      s_d.ctrl = `EMT_CTRL_RST;
      s_d.wid  = `EMT_WIDTH_RST;
      s_d.rsel = `EMT_REGSEL_RST;
    end
  end

  // --------------------------------------------------
  // state register
  // --------------------------------------------------
  // all state advances on every edge
  always_ff @(posedge sys_clk) begin
    s_q <= s_d;
  end

  // outputs straight from state
  assign wb_dat_o   = s_q.dat;
  assign wb_ack_o   = s_q.ack;
  assign port_rdata = s_q.dout;
  assign cam_res    = s_q.cres;
  assign cam_busy   = s_q.cst != emt_pkg::EMT_IDLE;
endmodule : emt_tile
`default_nettype wire

/* sim/emt_sva.sv */
// assertions on the ports of the embedded memory tile
`timescale 1ns/1ps
`default_nettype none
module emt_sva (
  input wire logic                   sys_clk,
  input wire logic                   resetn,
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   wb_ack_o,
  input wire emt_pkg::emt_ce_t [1:0] port_ce,
  input wire logic [1:0][31:0]       port_rdata,
  input wire emt_pkg::emt_cwr_t      cam_wreq,
  input wire logic                   cam_look,
  input wire emt_pkg::emt_cres_t     cam_res,
  input wire logic                   cam_busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ------------------------------
  // bus, ram and search timing
  // ------------------------------
  // bus answer one cycle after the request, one cycle long
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack too long");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  // local clear of port a empties its output one cycle later
  a_clr_out: assert property (port_ce[0].clr |=> port_rdata[0] == 32'h0)
    else $error("port clear ignored");
  // content write busy for two cycles at most
  a_busy_len: assert property (cam_busy |=> ##[0:1] !cam_busy)
    else $error("busy too long");
  a_busy_cause: assert property ($rose(cam_busy) |-> $past(cam_wreq.wr))
    else $error("busy without write");
  // results only follow a lookup, never one refused while busy
  a_look_cause: assert property (cam_res.valid |-> $past(cam_look) || $past(cam_res.valid))
    else $error("result without lookup");
  a_busy_block: assert property (cam_res.valid && $past(cam_busy) |-> $past(cam_res.valid))
    else $error("lookup taken while busy");
  a_match_valid: assert property (cam_res.match |-> cam_res.valid)
    else $error("match flag without result");
  // main scenarios
  c_ack: cover property (wb_ack_o);
  c_mask_write: cover property (cam_busy ##1 cam_busy);
  c_match: cover property (cam_res.match);
endmodule : emt_sva
bind emt_tile emt_sva sva_u (.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_ce(port_ce),
  .port_rdata(port_rdata), .cam_wreq(cam_wreq), .cam_look(cam_look), .cam_res(cam_res),
  .cam_busy(cam_busy));
`default_nettype wire

/* sim/emt_user.sv */
// user logic model driving the content search port
`timescale 1ns/1ps
`default_nettype none
module emt_user (
  input  wire logic               sys_clk,
  input  wire logic               cam_busy,
  input  wire emt_pkg::emt_cres_t cam_res,
  output var emt_pkg::emt_cwr_t   cam_wreq,
  output var logic                cam_look,
  output var logic [31:0]         cam_key
);
  // ------------------------------
  // search port requests
  // ------------------------------
  // idle levels at time zero
  initial begin
    cam_wreq = '0;
    cam_look = 1'b0;
    cam_key  = 32'h0;
  end
  // hold off while a content write is in progress
  task automatic wait_idle();
    @(posedge sys_clk);
    while (cam_busy !== 1'b0) @(posedge sys_clk);
  endtask : wait_idle
  // one word write, mask in a third cycle when asked
  task automatic put(input logic [4:0] a, input logic [31:0] d, input logic ce,
                     input logic [31:0] m);
    wait_idle();
    cam_wreq <= '{1'b1, a, d, ce, m};
    @(posedge sys_clk);
    cam_wreq <= '{1'b0, ~a, ~d, 1'b0, ~m};
    wait_idle();
  endtask : put
  // lookup, returns the two result cycles
  task automatic find(input logic [31:0] k, output emt_pkg::emt_cres_t r1,
                      output emt_pkg::emt_cres_t r2);
    wait_idle();
    cam_look <= 1'b1;
    cam_key  <= k;
    @(posedge sys_clk);
    cam_look <= 1'b0;
    cam_key  <= ~k;
    @(posedge sys_clk);
    r1 = cam_res;
    @(posedge sys_clk);
    r2 = cam_res;
  endtask : find
endmodule : emt_user
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench of the embedded memory tile
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                   sys_clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic                   cam_look, cam_busy;
  logic [7:0]             wb_adr_i;
  logic [3:0]             wb_sel_i;
  logic [31:0]            wb_dat_i, wb_dat_o, cam_key, rnd, d, rd;
  logic [15:0]            ea, w2;
  emt_pkg::emt_req_t [1:0] port_req;
  emt_pkg::emt_ce_t [1:0] port_ce;
  logic [1:0][31:0]       port_rdata;
  emt_pkg::emt_cwr_t      cam_wreq;
  emt_pkg::emt_cres_t     cam_res, r1, r2;
  int                     bad_count, compares;
  localparam logic [7:0]  ctl_m[3] = '{8'h24, 8'h44, 8'h84};
  localparam logic [16:0] exp_1[3] = '{17'h10028, 17'h10028, 17'h10006};
  localparam logic [16:0] exp_2[3] = '{17'h10000, 17'h00000, 17'h00000};
  emt_tile dut_u (.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_req(port_req),
    .port_ce(port_ce), .port_rdata(port_rdata), .cam_wreq(cam_wreq), .cam_look(cam_look),
    .cam_key(cam_key), .cam_res(cam_res), .cam_busy(cam_busy));
  emt_user user_u (.sys_clk(sys_clk), .cam_busy(cam_busy), .cam_res(cam_res),
    .cam_wreq(cam_wreq), .cam_look(cam_look), .cam_key(cam_key));
  // ------------------------------
  // clock, helpers
  // ------------------------------
  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one classic bus cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= wd;
    // only the watchdog ends a wait that never sees ack
    do begin
      @(posedge sys_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  // watchdog against a hang
  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    port_req = '0;
    port_ce = '0;
    bad_count = 0;
    compares = 0;
    rnd = 32'h00000053;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    // reset values, unmapped write ignored
    wb(1'b1, 8'h10, 32'hffffffff);
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    // quad: A written x1 read x16, B x16, both writes then both reads at once
    wb(1'b1, 8'h04, 32'h00000920);
    port_ce <= 6'h36;
    rnd = lfsr(rnd);
    w2 = rnd[31:16];
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      rnd = lfsr(rnd);
      ea[i] = rnd[0];
      port_req[0] <= '{1'b1, 12'(16 + i), {31'h0, rnd[0]}, 1'b0, 12'h0};
      port_req[1] <= '{1'b1, 12'h002, {16'h0, w2}, 1'b0, 12'h0};
    end
    @(posedge sys_clk);
    port_req[0] <= '{1'b0, 12'h0, 32'h0, 1'b1, 12'h001};
    port_req[1] <= '{1'b0, 12'h0, 32'h0, 1'b1, 12'h002};
    @(posedge sys_clk);
    port_req <= '0;
    @(posedge sys_clk);
    chk(port_rdata[0], {16'h0, ea});
    chk(port_rdata[1], {16'h0, w2});
    port_ce[0].clr <= 1'b1;
    @(posedge sys_clk);
    port_ce[0].clr <= 1'b0;
    @(posedge sys_clk);
    chk(port_rdata[0], 32'h0);
    chk(port_rdata[1], {16'h0, w2});
    // illegal shapes refused, 32-bit allowed in dual port
    wb(1'b1, 8'h04, 32'h00000925);
    wb(1'b1, 8'h00, 32'h00000002);
    wb(1'b1, 8'h04, 32'h00000028);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h00000920);
    wb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h00000001);
    wb(1'b1, 8'h0c, 32'h00000001);
    wb(1'b1, 8'h04, 32'h00000b6d);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h00000b6d);
    wb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    // dual port, input/output clocking, output stage on port b
    wb(1'b1, 8'h00, 32'h00000012);
    wb(1'b1, 8'h08, 32'h00000800);
    rnd = lfsr(rnd);
    @(posedge sys_clk);
    port_req[0] <= '{1'b1, 12'h003, rnd, 1'b1, 12'h003};
    @(posedge sys_clk);
    port_req[0] <= '0;
    port_req[1] <= '{1'b0, 12'h000, 32'h0, 1'b1, 12'h003};
    port_ce[1].rd_ce <= 1'b0;
    @(posedge sys_clk);
    port_req[1] <= '0;
    port_ce[1].rd_ce <= 1'b1;
    @(posedge sys_clk);
    chk(port_rdata[1], {16'h0, w2});
    @(posedge sys_clk);
    chk(port_rdata[1], rnd);
    chk(port_rdata[0], 32'h0);
    // content store: plain word and masked word
    wb(1'b1, 8'h00, 32'h00000004);
    rnd = lfsr(rnd);
    d = {1'b0, rnd[30:17], 1'b1, rnd[15:0]};
    user_u.put(5'h05, d, 1'b0, 32'h0);
    user_u.put(5'h03, d, 1'b1, 32'h000000ff);
    user_u.find(d ^ 32'h000000ff, r1, r2);
    chk({r1.valid, r1.match, r1.addr}, {2'b11, 5'h03});
    user_u.find(~d, r1, r2);
    chk({r1.valid, r1.match}, 2'b10);
    // multiple, fast multiple and unencoded single match
    for (int m = 0; m < 3; m++) begin
      wb(1'b1, 8'h00, {24'h0, ctl_m[m]});
      user_u.find(m == 2 ? d | 32'h80000000 : d, r1, r2);
      chk({r1.valid, r1.lines}, exp_1[m]);
      chk({r2.valid, r2.lines}, exp_2[m]);
    end
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
